// File: verilog/smr_pkg.sv
package smr_pkg;

   // command pin codes, order {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0]  CMD_MODE_SET    = 4'h0;
   localparam logic [3:0]  CMD_REFRESH     = 4'h1;
   localparam logic [3:0]  CMD_WRITE       = 4'h4;
   localparam logic [3:0]  CMD_DESELECT    = 4'hf;

   // bank address of the mode registers
   localparam logic [2:0]  BA_LEVELING_MR  = 3'h1;
   localparam logic [2:0]  BA_REFRESH_MR   = 3'h2;

   localparam int          ADDR_W          = 14;

   // refresh_latency_mode_reg field positions on the address pins
   localparam int          RANGE_LSB       = 0;
   localparam int          WLAT_LSB        = 3;
   localparam int          AUTO_TEMP_BIT   = 6;
   localparam int          HOT_RANGE_BIT   = 7;
   localparam int          RTT_WR_LSB      = 9;
   // driver_leveling_mode_reg field positions
   localparam int          LEVEL_BIT       = 7;
   localparam int          NOM_TERM_B0     = 2;
   localparam int          NOM_TERM_B1     = 6;
   localparam int          NOM_TERM_B2     = 9;

   // reset values
   localparam logic [2:0]  RANGE_RST       = 3'h0;
   localparam logic [2:0]  WLAT_RST        = 3'h0;
   localparam logic [1:0]  RTT_WR_RST      = 2'h0;
   localparam logic [2:0]  NOM_TERM_RST    = 3'h0;

   localparam logic [3:0]  WLAT_BASE_CYCLES = 4'h5;
   localparam logic [2:0]  WLAT_MAX_CODE   = 3'h3;
   localparam logic [1:0]  RTT_WR_OFF      = 2'h0;
   localparam logic [1:0]  RTT_WR_MAX      = 2'h2;
   localparam logic [2:0]  BURST_CLKS      = 3'h4;

   // clock and write latency choice
   localparam int          CLK_PERIOD_PS   = 10000;
   localparam int          WLAT5_MIN_PS    = 2500;
   localparam int          WLAT6_MIN_PS    = 1875;
   localparam int          WLAT7_MIN_PS    = 1500;

   // refresh interval, longest time so rounded down
   localparam int          REFRESH_INTERVAL_NS = 7800;
   localparam int          CLK_PERIOD_NS       = 10;
   localparam logic [9:0]  REFRESH_CYCLES      = 10'(REFRESH_INTERVAL_NS / CLK_PERIOD_NS);
   localparam logic [9:0]  REFRESH_MARGIN      = 10'h008;

   // controller apb map
   localparam logic [11:0] OFS_CTRL        = 12'h000;
   localparam logic [11:0] OFS_CMD         = 12'h004;
   localparam logic [11:0] OFS_STATUS      = 12'h008;
   localparam int          CTRL_W          = 12;
   localparam logic [11:0] CTRL_RST        = 12'h000;
   localparam int          CTRL_RANGE_LSB  = 0;
   localparam int          CTRL_AUTO_TEMP_BIT = 3;
   localparam int          CTRL_HOT_BIT    = 4;
   localparam int          CTRL_RTT_WR_LSB = 5;
   localparam int          CTRL_LEVEL_BIT  = 7;
   localparam int          CTRL_NOM_LSB    = 8;
   localparam int          CTRL_AUTO_REF   = 11;
   localparam int          CMD_ENTER_BIT   = 2;
   localparam logic [1:0]  OP_LOAD_REFRESH = 2'h0;
   localparam logic [1:0]  OP_LOAD_LEVEL   = 2'h1;
   localparam logic [1:0]  OP_WRITE        = 2'h2;
   localparam logic [1:0]  OP_SELF_REFRESH = 2'h3;

   function automatic logic [3:0] wlat_cycles(input logic [2:0] code);
      wlat_cycles = WLAT_BASE_CYCLES + {1'b0, code};
   endfunction

   function automatic logic [2:0] wlat_for_period(input int period_ps);
      if (period_ps >= WLAT5_MIN_PS) begin
         wlat_for_period = 3'h0;
      end else if (period_ps >= WLAT6_MIN_PS) begin
         wlat_for_period = 3'h1;
      end else if (period_ps >= WLAT7_MIN_PS) begin
         wlat_for_period = 3'h2;
      end else begin
         wlat_for_period = 3'h3;
      end
   endfunction

   function automatic logic [7:0] range_retain(input logic [2:0] code);
      case (code)
         3'h0:    range_retain = 8'hff;
         3'h1:    range_retain = 8'h0f;
         3'h2:    range_retain = 8'h03;
         3'h3:    range_retain = 8'h01;
         3'h4:    range_retain = 8'hfc;
         3'h5:    range_retain = 8'hf0;
         3'h6:    range_retain = 8'hc0;
         default: range_retain = 8'h80;
      endcase
   endfunction

endpackage

// File: verilog/smr_cmd_if.sv
interface smr_cmd_if;
   logic                       cs_n;
   logic                       ras_n;
   logic                       cas_n;
   logic                       we_n;
   logic                       cke;
   logic [2:0]                 ba;
   logic [smr_pkg::ADDR_W-1:0] addr;

   modport ctrl (
      output cs_n,
      output ras_n,
      output cas_n,
      output we_n,
      output cke,
      output ba,
      output addr
   );

   modport mem (
      input cs_n,
      input ras_n,
      input cas_n,
      input we_n,
      input cke,
      input ba,
      input addr
   );
endinterface

// File: verilog/smr_mode_reg_dev.sv
// Contract
// - mode set with bank 010 loads register
// - controller zeroes A13, A12, A11
// - A[2:0] picks banks kept in self refresh
// - banks outside range lost in self refresh
// - controller refreshes within interval outside self refresh
// - first write beat after programmed latency
// - latency codes 0..3 give 5..8 cycles
// - controller picks latency from clock period
// - A6 selects automatic self refresh rate
// - controller sets A7 above 105 degrees
// - A[10:9] picks write termination off/60/120
// - write termination works without nominal termination
// - no dynamic termination during write leveling
// - leveling follows bit 7 of driver register
module smr_mode_reg_dev (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   smr_cmd_if.mem          cmd_bus,
   input  wire logic       die_hot_in,
   output logic [7:0]      bank_retain_out,
   output logic [7:0]      bank_lost_out,
   output logic [3:0]      write_latency_out,
   output logic            auto_temp_self_refresh_out,
   output logic            extended_temp_refresh_select_out,
   output logic            ext_refresh_rate_out,
   output logic            self_refresh_out,
   output logic            first_beat_out,
   output logic [1:0]      write_term_sel_out,
   output logic [2:0]      nominal_termination_out,
   output logic            write_leveling_out,
   output logic            reserved_code_out
);

   typedef struct packed {
      logic [2:0] partial_refresh_bank_range;
      logic [2:0] write_data_latency;
      logic       auto_temp_self_refresh;
      logic       extended_temp_refresh_select;
      logic [1:0] write_term;
      logic       leveling;
      logic [2:0] nominal_termination;
      logic       self_ref;
      logic [3:0] lat_cnt;
      logic [2:0] burst_cnt;
      logic       first_beat;
      logic [1:0] term_sel;
      logic [7:0] retain;
      logic [7:0] lost;
      logic [3:0] latency;
      logic       ext_rate;
      logic       reserved;
   } smr_dev_state_t;

   smr_dev_state_t state_reg;
   smr_dev_state_t state_next;

   logic [3:0]     cmd;
   logic           load_refresh_mr;
   logic           load_level_mr;
   logic           term_window;

   logic [2:0]     range_field;
   logic [2:0]     latency_field;
   logic           auto_field;
   logic           hot_field;
   logic [1:0]     term_field;
   logic [2:0]     nom_field;
   logic           reserved_load;
   logic           write_cmd;
   logic           self_ref_entry;

   assign cmd = {cmd_bus.cs_n, cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n};

   // decode mode set to bank 010 or bank 001
   assign load_refresh_mr = (cmd == smr_pkg::CMD_MODE_SET) && (cmd_bus.ba == smr_pkg::BA_REFRESH_MR);
   assign load_level_mr   = (cmd == smr_pkg::CMD_MODE_SET) && (cmd_bus.ba == smr_pkg::BA_LEVELING_MR);

   // fields as they stand on the address pins
   assign range_field   = cmd_bus.addr[smr_pkg::RANGE_LSB +: 3];
   assign latency_field = cmd_bus.addr[smr_pkg::WLAT_LSB +: 3];
   assign auto_field    = cmd_bus.addr[smr_pkg::AUTO_TEMP_BIT];
   assign hot_field     = cmd_bus.addr[smr_pkg::HOT_RANGE_BIT];
   assign term_field    = cmd_bus.addr[smr_pkg::RTT_WR_LSB +: 2];
   assign nom_field     = {cmd_bus.addr[smr_pkg::NOM_TERM_B2],
                           cmd_bus.addr[smr_pkg::NOM_TERM_B1],
                           cmd_bus.addr[smr_pkg::NOM_TERM_B0]};

   // latency codes above 011 and termination codes above 10 flagged reserved
   // reserved codes are still stored; the flag is the only warning
   assign reserved_load = (latency_field > smr_pkg::WLAT_MAX_CODE) ||
                          (term_field > smr_pkg::RTT_WR_MAX);

   assign write_cmd      = (cmd == smr_pkg::CMD_WRITE);
   // self refresh entry is a refresh with cke already low
   assign self_ref_entry = (cmd == smr_pkg::CMD_REFRESH) && !cmd_bus.cke;

   // burst occupies the beat cycle plus the following three
   assign term_window = (state_reg.lat_cnt == 4'h1) || (state_reg.burst_cnt > 3'h1);

   always_comb begin
      state_next = state_reg;
      state_next.first_beat = 1'b0;

      // latch every field on load
      // a13..a11 are ignored here; the controller keeps them zero
      if (load_refresh_mr) begin
         state_next.partial_refresh_bank_range = range_field;
         state_next.write_data_latency = latency_field;
         state_next.auto_temp_self_refresh = auto_field;
         state_next.extended_temp_refresh_select = hot_field;
         state_next.write_term = term_field;
         state_next.reserved = reserved_load;
      end

      // leveling mode tracks driver register bit 7
      if (load_level_mr) begin
         state_next.leveling = cmd_bus.addr[smr_pkg::LEVEL_BIT];
         state_next.nominal_termination = nom_field;
      end

      // self refresh: refresh with cke low enters, cke high leaves
      if (self_ref_entry) begin
         state_next.self_ref = 1'b1;
      end else if (cmd_bus.cke) begin
         state_next.self_ref = 1'b0;
      end

      state_next.latency = smr_pkg::wlat_cycles(state_next.write_data_latency);

      // count latency from write command
      // one less, since the beat flag leaves through a flop
      // a later write restarts the count; no overlapping bursts tracked
      if (write_cmd) begin
         state_next.lat_cnt = state_reg.latency - 4'h1;
      end else if (state_reg.lat_cnt != 4'h0) begin
         state_next.lat_cnt = state_reg.lat_cnt - 4'h1;
      end

      if (state_reg.lat_cnt == 4'h1) begin
         state_next.first_beat = 1'b1;
         state_next.burst_cnt = smr_pkg::BURST_CLKS;
      end else if (state_reg.burst_cnt != 3'h0) begin
         state_next.burst_cnt = state_reg.burst_cnt - 3'h1;
      end

      // suppressed while leveling
      // next leveling value, so no stray code on the mode edge
      if (term_window && !state_next.leveling && (state_reg.write_term <= smr_pkg::RTT_WR_MAX)) begin
         state_next.term_sel = state_reg.write_term;
      end else begin
         state_next.term_sel = smr_pkg::RTT_WR_OFF;
      end

      state_next.retain = smr_pkg::range_retain(state_next.partial_refresh_bank_range);

      // outside banks only lost once in self refresh
      state_next.lost = state_next.self_ref ? ~state_next.retain : 8'h00;

      // sensor decides when automatic, else manual range
      state_next.ext_rate = state_next.auto_temp_self_refresh ? die_hot_in
                                                              : state_next.extended_temp_refresh_select;
   end

   always_ff @(posedge sys_clk_in) begin
      // all banks kept, shortest latency, no termination
      if (rst_in) begin
         state_reg <= '{partial_refresh_bank_range:   smr_pkg::RANGE_RST,
                        write_data_latency:           smr_pkg::WLAT_RST,
                        auto_temp_self_refresh:       1'b0,
                        extended_temp_refresh_select: 1'b0,
                        write_term:                   smr_pkg::RTT_WR_RST,
                        leveling:                     1'b0,
                        nominal_termination:          smr_pkg::NOM_TERM_RST,
                        self_ref:                     1'b0,
                        lat_cnt:                      4'h0,
                        burst_cnt:                    3'h0,
                        first_beat:                   1'b0,
                        term_sel:                     smr_pkg::RTT_WR_OFF,
                        retain:                       8'hff,
                        lost:                         8'h00,
                        latency:                      smr_pkg::WLAT_BASE_CYCLES,
                        ext_rate:                     1'b0,
                        reserved:                     1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // every output straight from the state flop
   assign bank_retain_out                  = state_reg.retain;
   assign bank_lost_out                    = state_reg.lost;
   assign write_latency_out                = state_reg.latency;
   assign auto_temp_self_refresh_out       = state_reg.auto_temp_self_refresh;
   assign extended_temp_refresh_select_out = state_reg.extended_temp_refresh_select;
   assign ext_refresh_rate_out             = state_reg.ext_rate;
   assign self_refresh_out                 = state_reg.self_ref;
   assign first_beat_out                   = state_reg.first_beat;
   assign write_term_sel_out               = state_reg.term_sel;
   assign nominal_termination_out          = state_reg.nominal_termination;
   assign write_leveling_out               = state_reg.leveling;
   assign reserved_code_out                = state_reg.reserved;

endmodule

// File: verilog/smr_ctrl.sv
module smr_ctrl (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   smr_cmd_if.ctrl          cmd_bus
);

   typedef enum logic {
      CS_IDLE  = 1'b0,
      CS_DRIVE = 1'b1
   } smr_ctl_state_t;

   typedef struct packed {
      smr_ctl_state_t              fsm;
      logic [smr_pkg::CTRL_W-1:0]  ctrl;
      logic                        pend;
      logic [1:0]                  op;
      logic                        enter;
      logic                        self_ref;
      logic [9:0]                  ref_cnt;
      logic [7:0]                  ref_total;
      logic [3:0]                  cmd;
      logic                        cke;
      logic [2:0]                  ba;
      logic [smr_pkg::ADDR_W-1:0]  addr;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
   } smr_ctl_t;

   smr_ctl_t s_reg;
   smr_ctl_t s_next;

   // latency fixed by the clock period
   localparam logic [2:0] WLAT_CODE = smr_pkg::wlat_for_period(smr_pkg::CLK_PERIOD_PS);

   logic                       access;
   logic                       busy;
   logic                       ref_due;
   logic [smr_pkg::ADDR_W-1:0] refresh_mr_addr;
   logic [smr_pkg::ADDR_W-1:0] level_mr_addr;

   assign access  = psel_in && penable_in && s_reg.pready;
   assign busy    = s_reg.pend || (s_reg.fsm != CS_IDLE);
   assign ref_due = s_reg.ref_cnt >= (smr_pkg::REFRESH_CYCLES - smr_pkg::REFRESH_MARGIN);

   // a13, a12, a11 and a8 driven zero
   // hot operation sets the extended range bit
   assign refresh_mr_addr = {3'h0,
                             s_reg.ctrl[smr_pkg::CTRL_RTT_WR_LSB +: 2],
                             1'b0,
                             s_reg.ctrl[smr_pkg::CTRL_HOT_BIT],
                             s_reg.ctrl[smr_pkg::CTRL_AUTO_TEMP_BIT],
                             WLAT_CODE,
                             s_reg.ctrl[smr_pkg::CTRL_RANGE_LSB +: 3]};
   assign level_mr_addr   = {4'h0,
                             s_reg.ctrl[smr_pkg::CTRL_NOM_LSB + 2],
                             1'b0,
                             s_reg.ctrl[smr_pkg::CTRL_LEVEL_BIT],
                             s_reg.ctrl[smr_pkg::CTRL_NOM_LSB + 1],
                             3'h0,
                             s_reg.ctrl[smr_pkg::CTRL_NOM_LSB],
                             2'h0};

   always_comb begin
      s_next = s_reg;
      // replies prepared in setup so pready comes from a flop
      s_next.pready  = psel_in && !penable_in;
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h0000_0000;
      if (psel_in && !penable_in) begin
         unique case (paddr_in)
            smr_pkg::OFS_CTRL:   s_next.prdata = {20'h0_0000, s_reg.ctrl};
            smr_pkg::OFS_CMD:    s_next.prdata = 32'h0000_0000;
            smr_pkg::OFS_STATUS: s_next.prdata = {16'h0000, s_reg.ref_total, 3'h0, WLAT_CODE,
                                                  s_reg.self_ref, busy};
            default:             s_next.pslverr = 1'b1;
         endcase
      end
      if (access && pwrite_in && (paddr_in == smr_pkg::OFS_CTRL)) begin
         s_next.ctrl = pwdata_in[smr_pkg::CTRL_W-1:0];
      end
      // command writes while busy are dropped
      if (access && pwrite_in && (paddr_in == smr_pkg::OFS_CMD) && !busy) begin
         s_next.pend  = 1'b1;
         s_next.op    = pwdata_in[1:0];
         s_next.enter = pwdata_in[smr_pkg::CMD_ENTER_BIT];
      end

      // refresh timer held at zero while in self refresh
      if (s_reg.self_ref) begin
         s_next.ref_cnt = 10'h000;
      end else if (!ref_due) begin
         s_next.ref_cnt = s_reg.ref_cnt + 10'h001;
      end

      s_next.cmd  = smr_pkg::CMD_DESELECT;
      s_next.ba   = 3'h0;
      s_next.addr = '0;
      unique case (s_reg.fsm)
         CS_IDLE: begin
            if (ref_due && s_reg.ctrl[smr_pkg::CTRL_AUTO_REF] && !s_reg.self_ref) begin
               s_next.cmd       = smr_pkg::CMD_REFRESH;
               s_next.ref_cnt   = 10'h000;
               s_next.ref_total = s_reg.ref_total + 8'h01;
               s_next.fsm       = CS_DRIVE;
            end else if (s_reg.pend) begin
               s_next.pend = 1'b0;
               s_next.fsm  = CS_DRIVE;
               unique case (s_reg.op)
                  smr_pkg::OP_LOAD_REFRESH: begin
                     s_next.cmd  = smr_pkg::CMD_MODE_SET;
                     s_next.ba   = smr_pkg::BA_REFRESH_MR;
                     s_next.addr = refresh_mr_addr;
                  end
                  smr_pkg::OP_LOAD_LEVEL: begin
                     s_next.cmd  = smr_pkg::CMD_MODE_SET;
                     s_next.ba   = smr_pkg::BA_LEVELING_MR;
                     s_next.addr = level_mr_addr;
                  end
                  smr_pkg::OP_WRITE: begin
                     s_next.cmd = smr_pkg::CMD_WRITE;
                  end
                  smr_pkg::OP_SELF_REFRESH: begin
                     if (s_reg.enter && !s_reg.self_ref) begin
                        s_next.cmd      = smr_pkg::CMD_REFRESH;
                        s_next.cke      = 1'b0;
                        s_next.self_ref = 1'b1;
                     end else if (!s_reg.enter) begin
                        s_next.cke      = 1'b1;
                        s_next.self_ref = 1'b0;
                     end
                  end
               endcase
            end
         end
         CS_DRIVE: begin
            s_next.fsm = CS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_reg <= '{fsm: CS_IDLE, ctrl: smr_pkg::CTRL_RST, pend: 1'b0, op: 2'h0, enter: 1'b0,
                    self_ref: 1'b0, ref_cnt: 10'h000, ref_total: 8'h00,
                    cmd: smr_pkg::CMD_DESELECT, cke: 1'b1, ba: 3'h0, addr: '0,
                    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata_out    = s_reg.prdata;
   assign pready_out    = s_reg.pready;
   assign pslverr_out   = s_reg.pslverr;
   assign cmd_bus.cs_n  = s_reg.cmd[3];
   assign cmd_bus.ras_n = s_reg.cmd[2];
   assign cmd_bus.cas_n = s_reg.cmd[1];
   assign cmd_bus.we_n  = s_reg.cmd[0];
   assign cmd_bus.cke   = s_reg.cke;
   assign cmd_bus.ba    = s_reg.ba;
   assign cmd_bus.addr  = s_reg.addr;

endmodule

// File: testbench/smr_chk_sva.sv
module smr_chk_sva (
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  ba,
   input wire logic [13:0] addr,
   input wire logic [7:0]  bank_retain_out,
   input wire logic [3:0]  write_latency_out,
   input wire logic        auto_temp_self_refresh_out,
   input wire logic        first_beat_out,
   input wire logic [1:0]  write_term_sel_out,
   input wire logic        write_leveling_out,
   input wire logic        reserved_code_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   wire logic       ld   = pins == smr_pkg::CMD_MODE_SET && ba == smr_pkg::BA_REFRESH_MR;
   wire logic       wr   = pins == smr_pkg::CMD_WRITE;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   chk_load_latency: assert property (
      ld |=> write_latency_out == 4'h5 + {1'b0, $past(addr[5:3])}) else $error("latency not from load");
   chk_range_full: assert property (
      ld && addr[2:0] == 3'h0 |=> bank_retain_out == 8'hff) else $error("full range not kept");
   chk_range_upper: assert property (
      ld && addr[2:0] == 3'h5 |=> bank_retain_out == 8'hf0) else $error("upper half not kept");
   chk_auto_temp: assert property (
      ld |=> auto_temp_self_refresh_out == $past(addr[6])) else $error("auto temp bit not latched");
   chk_reserved_term: assert property (
      ld && addr[10:9] == 2'h3 |=> reserved_code_out) else $error("reserved code not flagged");
   chk_first_beat: assert property (
      wr && write_latency_out == 4'h5 |-> ##5 first_beat_out) else $error("first beat late or missing");
   chk_term_burst: assert property (
      first_beat_out && write_term_sel_out == 2'h1 |=> (write_term_sel_out == 2'h1) [*3])
      else $error("termination window short");
   chk_no_dyn_term: assert property (
      write_leveling_out |-> write_term_sel_out == 2'h0) else $error("termination during leveling");
   chk_cmd_spacing: assert property (
      !cs_n |=> cs_n) else $error("commands back to back");
endmodule

// File: testbench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, die_hot, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  retain, lost, c;
   logic [3:0]  lat;
   logic        auto_o, hot_o, rate_o, sr_o, beat_o, lvl_o, rsv_o;
   logic [1:0]  term_o, beat_term;
   logic [2:0]  nom_o, ld_ba;
   logic [13:0] ld_addr;
   int          mismatches = 0, comparisons = 0, cyc = 0, wr_cyc = 0, beat_dly = 0, refs = 0;
   logic [7:0]  cw_t [4] = '{8'h00, 8'h29, 8'h55, 8'h7a};
   logic [7:0]  ret_t [4] = '{8'hff, 8'h0f, 8'hf0, 8'h03};
   smr_cmd_if bus ();
   wire logic [3:0] pins = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
   smr_ctrl i_smr_ctrl (.sys_clk_in(clk), .rst_in(rst), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .cmd_bus(bus));
   smr_mode_reg_dev i_smr_mode_reg_dev (.sys_clk_in(clk), .rst_in(rst), .cmd_bus(bus),
      .die_hot_in(die_hot), .bank_retain_out(retain), .bank_lost_out(lost), .write_latency_out(lat),
      .auto_temp_self_refresh_out(auto_o), .extended_temp_refresh_select_out(hot_o),
      .ext_refresh_rate_out(rate_o), .self_refresh_out(sr_o), .first_beat_out(beat_o),
      .write_term_sel_out(term_o), .nominal_termination_out(nom_o), .write_leveling_out(lvl_o),
      .reserved_code_out(rsv_o));
   smr_chk_sva i_smr_chk_sva (.sys_clk_in(clk), .rst_in(rst), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
      .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr), .bank_retain_out(retain),
      .write_latency_out(lat), .auto_temp_self_refresh_out(auto_o), .first_beat_out(beat_o),
      .write_term_sel_out(term_o), .write_leveling_out(lvl_o), .reserved_code_out(rsv_o));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // wire watcher, timing measured in edges
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pins === smr_pkg::CMD_MODE_SET) begin
         ld_addr <= bus.addr;
         ld_ba <= bus.ba;
      end
      if (pins === smr_pkg::CMD_WRITE) wr_cyc <= cyc;
      if (pins === smr_pkg::CMD_REFRESH && bus.cke === 1'b1) refs <= refs + 1;
      if (beat_o === 1'b1) begin
         beat_dly <= cyc - wr_cyc;
         beat_term <= term_o;
      end
   end
   task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // busy poll, then room for latency plus burst window
   task issue(input logic [31:0] op);
      apb(smr_pkg::OFS_CMD, 1'b1, op);
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(smr_pkg::OFS_STATUS, 1'b0, 32'h0);
      repeat (10) @(posedge clk);
   endtask
   task close_out;
      if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out;
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, die_hot} = {1'b1, 48'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(smr_pkg::OFS_CTRL, 1'b0, 32'h0);
      cmp("ctrl_rst", 32'h0, rd);
      cmp("lat_rst", 32'h5, lat);
      apb(12'h00c, 1'b0, 32'h0);
      cmp("unmapped_err", 32'h1, err);
      cmp("unmapped_rd", 32'h0, rd);
      // auto refresh off so orders go out at once
      for (int i = 0; i < 4; i++) begin
         c = cw_t[i];
         die_hot <= i[0];
         apb(smr_pkg::OFS_CTRL, 1'b1, {24'h0, c});
         issue(32'h0);
         cmp("ld_ba", 32'h2, ld_ba);
         cmp("ld_addr", {3'h0, c[6:5], 1'b0, c[4], c[3], 3'h0, c[2:0]}, ld_addr);
         cmp("retain", ret_t[i], retain);
         cmp("auto_temp", c[3], auto_o);
         cmp("hot_range", c[4], hot_o);
         cmp("rate", c[3] ? i[0] : c[4], rate_o);
         cmp("lat", 32'h5, lat);
         cmp("rsv", c[6:5] == 2'h3, rsv_o);
         issue(32'h2);
         cmp("beat_dly", 32'h5, beat_dly);
         cmp("beat_term", c[6:5] == 2'h3 ? 2'h0 : c[6:5], beat_term);
      end
      apb(smr_pkg::OFS_CTRL, 1'b1, 32'ha9);
      issue(32'h1);
      cmp("level_on", 32'h1, lvl_o);
      issue(32'h2);
      cmp("level_term", 32'h0, beat_term);
      apb(smr_pkg::OFS_CTRL, 1'b1, 32'h29);
      issue(32'h1);
      cmp("level_off", 32'h0, lvl_o);
      issue(32'h0);
      issue(32'h7);
      cmp("sr_on", 32'h1, sr_o);
      cmp("lost", 32'hf0, lost);
      cmp("status_sr", 32'h1, rd[1]);
      cmp("status_wlat", 32'h0, rd[4:2]);
      issue(32'h3);
      cmp("sr_off", 32'h0, sr_o);
      cmp("lost_off", 32'h0, lost);
      apb(smr_pkg::OFS_CTRL, 1'b1, 32'h829);
      repeat (800) @(posedge clk);
      cmp("refresh_seen", 32'h1, refs > 0);
      apb(smr_pkg::OFS_STATUS, 1'b0, 32'h0);
      cmp("status_refs", 32'h1, rd[15:8] != 8'h00);
      close_out;
   end
endmodule
